// [hdl/lock_prot_pkg.sv]
package lock_prot_pkg;
    // protection byte field positions
    localparam int EXT_LO_POS  = 0;
    localparam int EXT_HI_POS  = 1;
    localparam int APP_LO_POS  = 2;
    localparam int APP_HI_POS  = 3;
    localparam int BOOT_LO_POS = 4;
    localparam int BOOT_HI_POS = 5;
    localparam int LOCK_BITS   = 6;
    // value after reset and after whole-chip erase
    localparam logic [7:0] LOCK_DEFAULT = 8'hec;
    localparam logic [7:0] LOCK_ERASED  = 8'hff;
    localparam logic [7:0] UNUSED_MASK  = 8'hc0;
    // two-bit mode pair codes (hi, lo)
    localparam logic [1:0] PAIR_MODE1 = 2'h3;
    localparam logic [1:0] PAIR_MODE2 = 2'h2;
    localparam logic [1:0] PAIR_MODE3 = 2'h0;
    localparam logic [1:0] PAIR_MODE4 = 2'h1;
endpackage

// [hdl/lock_bit_protection.sv]
`timescale 1ns/100ps
// What this block does
// - six protection bits; 1 is unprogrammed, 0 is programmed and restricts.
// - writes never return protection bits to 1; whole-chip erase sets all six, reset reloads LOCK_DEFAULT.
// - byte layout boot hi/lo bits 5:4, app 3:2, ext 1:0; top two read 1.
// - external mode 1 imposes no external restriction.
// - external mode 2 blocks flash/eeprom programming and locks fuses.
// - external mode 3 also blocks verification and locks boot bits.
// - application mode 1 leaves application section unrestricted.
// - application mode 2 blocks self-program writes to application section.
// - application mode 3 blocks those writes and boot-code reads of application.
// - application mode 4 blocks boot-code reads of application section.
// - app modes 3/4 with boot vectors mask interrupts while in application.
// - boot mode 1 leaves boot section unrestricted.
// - boot mode 2 blocks self-program writes to boot section.
// - boot mode 3 blocks those writes and application-code reads of boot.
// - boot mode 4 blocks application-code reads of boot section.
// - boot modes 3/4 with application vectors mask interrupts while in boot.
module lock_bit_protection (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       chip_erase,
    input  wire logic       ext_prog_lock,
    input  wire logic [7:0] ext_prog_data,
    input  wire logic       self_prog_lock,
    input  wire logic [7:0] self_prog_data,
    input  wire logic       exec_in_boot,
    input  wire logic       vectors_in_boot,
    output logic      [7:0] lock_byte,
    output logic            ext_prog_block,
    output logic            ext_verify_block,
    output logic            fuse_lock,
    output logic            boot_bits_lock,
    output logic            app_write_block,
    output logic            app_read_block,
    output logic            boot_write_block,
    output logic            boot_read_block,
    output logic            irq_mask
);
    // stored protection bits and the value they take at the next edge
    logic [5:0] lock_ff;
    logic [5:0] nxt_lock;

    // per-requester write masks: a 0 programs a bit, a 1 leaves it alone
    logic [5:0] ext_mask;
    logic [5:0] cpu_mask;
    logic [5:0] prog_mask;

    // names for the four codes of a mode pair
    typedef enum logic [1:0] {
        PAIR_THREE = 2'h0,
        PAIR_FOUR  = 2'h1,
        PAIR_TWO   = 2'h2,
        PAIR_ONE   = 2'h3
    } pair_mode_e;

    // the three mode pairs
    pair_mode_e ext_mode;
    pair_mode_e app_mode;
    pair_mode_e boot_mode;

    // decoded permissions, registered one edge later
    logic       nxt_ext_prog_block;
    logic       nxt_ext_verify_block;
    logic       nxt_fuse_lock;
    logic       nxt_boot_bits_lock;
    logic       nxt_app_write_block;
    logic       nxt_app_read_block;
    logic       nxt_boot_write_block;
    logic       nxt_boot_read_block;
    logic       nxt_irq_mask;

    // map a hi/lo bit pair onto its mode
    function automatic pair_mode_e to_mode(input logic [1:0] m);
        case (m)
            lock_prot_pkg::PAIR_MODE1: to_mode = PAIR_ONE;
            lock_prot_pkg::PAIR_MODE2: to_mode = PAIR_TWO;
            lock_prot_pkg::PAIR_MODE3: to_mode = PAIR_THREE;
            default:                   to_mode = PAIR_FOUR;
        endcase
    endfunction

    // self-program writes into a section are refused in modes 2 and 3
    function automatic logic write_blk(input pair_mode_e m);
        case (m)
            PAIR_TWO:   write_blk = 1'b1;
            PAIR_THREE: write_blk = 1'b1;
            default:    write_blk = 1'b0;
        endcase
    endfunction

    // cross-section reads are refused in modes 3 and 4
    function automatic logic read_blk(input pair_mode_e m);
        case (m)
            PAIR_THREE: read_blk = 1'b1;
            PAIR_FOUR:  read_blk = 1'b1;
            default:    read_blk = 1'b0;
        endcase
    endfunction

    // external programming refused in every mode but mode 1
    function automatic logic ext_restricted(input pair_mode_e m);
        case (m)
            PAIR_ONE: ext_restricted = 1'b0;
            default:  ext_restricted = 1'b1;
        endcase
    endfunction

    // external verification refused and boot_bits_lock raised in mode 3 only
    function automatic logic ext_full_lock(input pair_mode_e m);
        case (m)
            PAIR_THREE: ext_full_lock = 1'b1;
            default:    ext_full_lock = 1'b0;
        endcase
    endfunction

    // interrupts off while running in one section with vectors in the other, if its reads are guarded
    function automatic logic irq_gate(input pair_mode_e far_mode, input logic vec_far, input logic run_near);
        irq_gate = read_blk(far_mode) && vec_far && run_near;
    endfunction

    // pair extraction, each pair on its own
    assign ext_mode  = to_mode({lock_ff[lock_prot_pkg::EXT_HI_POS],  lock_ff[lock_prot_pkg::EXT_LO_POS]});
    assign app_mode  = to_mode({lock_ff[lock_prot_pkg::APP_HI_POS],  lock_ff[lock_prot_pkg::APP_LO_POS]});
    assign boot_mode = to_mode({lock_ff[lock_prot_pkg::BOOT_HI_POS], lock_ff[lock_prot_pkg::BOOT_LO_POS]});

    // external lock write: boot and application bits frozen while fuses or boot bits are locked
    always_comb begin
        ext_mask = 6'h3f;
        if (ext_prog_lock) begin
            ext_mask = ext_prog_data[5:0];
            if (fuse_lock) begin
                ext_mask[5:2] = 4'hf;
            end
            if (boot_bits_lock) begin
                ext_mask[5:2] = 4'hf;
            end
        end
    end

    // cpu lock write reaches the boot and application bits only
    always_comb begin
        cpu_mask = 6'h3f;
        if (self_prog_lock) begin
            cpu_mask = {self_prog_data[5:2], 2'h3};
        end
    end

    // writes may only program bits; erase alone returns them to 1 and wins over writes
    always_comb begin
        prog_mask = ext_mask & cpu_mask;
        nxt_lock  = lock_ff & prog_mask;
        if (chip_erase) begin
            nxt_lock = lock_prot_pkg::LOCK_ERASED[5:0];
        end
    end

    // external programming refused outside mode 1
    always_comb begin
        nxt_ext_prog_block = ext_restricted(ext_mode);
    end

    // fuses locked outside external mode 1
    always_comb begin
        nxt_fuse_lock = ext_restricted(ext_mode);
    end

    // verification refused in external mode 3
    always_comb begin
        nxt_ext_verify_block = ext_full_lock(ext_mode);
    end

    // boot and application bits locked in external mode 3
    always_comb begin
        nxt_boot_bits_lock = ext_full_lock(ext_mode);
    end

    // self-program writes into the application section
    always_comb begin
        nxt_app_write_block = write_blk(app_mode);
    end

    // reads of the application section by boot code
    always_comb begin
        nxt_app_read_block = read_blk(app_mode) && exec_in_boot;
    end

    // self-program writes into the boot section
    always_comb begin
        nxt_boot_write_block = write_blk(boot_mode);
    end

    // reads of the boot section by application code
    always_comb begin
        nxt_boot_read_block = read_blk(boot_mode) && !exec_in_boot;
    end

    // interrupt gating in either direction
    always_comb begin
        nxt_irq_mask = irq_gate(app_mode, vectors_in_boot, !exec_in_boot)
                    || irq_gate(boot_mode, !vectors_in_boot, exec_in_boot);
    end

    // lock storage, reloaded with the default at reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lock_ff <= lock_prot_pkg::LOCK_DEFAULT[5:0];
        end else begin
            lock_ff <= nxt_lock;
        end
    end

    // protection byte image, unused top bits read 1
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lock_byte <= lock_prot_pkg::LOCK_DEFAULT;
        end else begin
            lock_byte <= {lock_prot_pkg::UNUSED_MASK[7:6], lock_ff};
        end
    end

    // external programming permission, updated on the same edge as the byte
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ext_prog_block <= 1'b1;
        end else begin
            ext_prog_block <= nxt_ext_prog_block;
        end
    end

    // external verification permission
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ext_verify_block <= 1'b1;
        end else begin
            ext_verify_block <= nxt_ext_verify_block;
        end
    end

    // fuse lock
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fuse_lock <= 1'b1;
        end else begin
            fuse_lock <= nxt_fuse_lock;
        end
    end

    // boot and application bit lock
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            boot_bits_lock <= 1'b1;
        end else begin
            boot_bits_lock <= nxt_boot_bits_lock;
        end
    end

    // application write guard
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            app_write_block <= 1'b0;
        end else begin
            app_write_block <= nxt_app_write_block;
        end
    end

    // application read guard
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            app_read_block <= 1'b0;
        end else begin
            app_read_block <= nxt_app_read_block;
        end
    end

    // boot write guard
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            boot_write_block <= 1'b1;
        end else begin
            boot_write_block <= nxt_boot_write_block;
        end
    end

    // boot read guard
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            boot_read_block <= 1'b0;
        end else begin
            boot_read_block <= nxt_boot_read_block;
        end
    end

    // interrupt mask
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask <= 1'b0;
        end else begin
            irq_mask <= nxt_irq_mask;
        end
    end
endmodule

// [dv/lock_prot_sva.sv]
`timescale 1ns/100ps
module lock_prot_sva (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       chip_erase,
    input wire logic       ext_prog_lock,
    input wire logic       self_prog_lock,
    input wire logic       exec_in_boot,
    input wire logic       vectors_in_boot,
    input wire logic       ext_prog_block,
    input wire logic       ext_verify_block,
    input wire logic       fuse_lock,
    input wire logic       boot_bits_lock,
    input wire logic       app_write_block,
    input wire logic       app_read_block,
    input wire logic       boot_write_block,
    input wire logic       boot_read_block,
    input wire logic       irq_mask,
    input wire logic [7:0] ext_prog_data,
    input wire logic [7:0] lock_byte
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // byte image, erase and write latency
    unused_bits_a: assert property (lock_byte[7:6] == 2'h3) else $error("unused bits low");
    no_raise_a: assert property (|(lock_byte & ~$past(lock_byte)) |-> $past(chip_erase, 2))
        else $error("bit raised");
    erase_all_a: assert property (chip_erase ##1 !(ext_prog_lock || self_prog_lock) |-> ##1 lock_byte == 8'hff)
        else $error("erase");
    write_lag_a: assert property (ext_prog_lock && !ext_prog_data[0] && !chip_erase |-> ##2 !lock_byte[0])
        else $error("latency");
    // permissions decoded from the byte
    ext_mode_a: assert property ({ext_prog_block, fuse_lock, ext_verify_block}
        == {lock_byte[1:0] != 2'h3, lock_byte[1:0] != 2'h3, lock_byte[1:0] == 2'h0}) else $error("ext mode");
    boot_lock_a: assert property (boot_bits_lock == (lock_byte[1:0] == 2'h0))
        else $error("boot bits lock");
    write_block_a: assert property ({app_write_block, boot_write_block} == ~{lock_byte[2], lock_byte[4]})
        else $error("write block");
    app_read_a: assert property (app_read_block == (!lock_byte[3] && $past(exec_in_boot)))
        else $error("app read");
    boot_read_a: assert property (boot_read_block == (!lock_byte[5] && !$past(exec_in_boot)))
        else $error("boot read");
    irq_gate_a: assert property (irq_mask == ((!lock_byte[3] && $past(vectors_in_boot) && !$past(exec_in_boot))
        || (!lock_byte[5] && !$past(vectors_in_boot) && $past(exec_in_boot)))) else $error("irq");
endmodule
bind lock_bit_protection lock_prot_sva u_sva (.*);

// [dv/prog_model.sv]
`timescale 1ns/100ps
module prog_model (
    input  wire logic       clk_sys,
    output logic            chip_erase,
    output logic            ext_prog_lock,
    output logic            self_prog_lock,
    output logic            exec_in_boot,
    output logic            vectors_in_boot,
    output logic      [7:0] ext_prog_data,
    output logic      [7:0] self_prog_data
);
    // idle: no request, data lines inverted
    initial {chip_erase, ext_prog_lock, self_prog_lock, exec_in_boot, vectors_in_boot} = 5'h0;
    initial {ext_prog_data, self_prog_data} = 16'hffff;
    // one-cycle request {erase, ext, cpu}; data valid only with the strobe
    task automatic req(input logic [2:0] k, input logic [7:0] d, input logic e, input logic v);
        @(posedge clk_sys);
        {chip_erase, ext_prog_lock, self_prog_lock} <= k;
        {ext_prog_data, self_prog_data, exec_in_boot, vectors_in_boot} <= {d, d, e, v};
        @(posedge clk_sys);
        {chip_erase, ext_prog_lock, self_prog_lock} <= 3'h0;
        {ext_prog_data, self_prog_data} <= ~{d, d};
    endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/100ps
module tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    int   errors = 0;
    int   n_compared = 0;
    logic chip_erase, ext_prog_lock, self_prog_lock, exec_in_boot, vectors_in_boot, ext_prog_block;
    logic ext_verify_block, fuse_lock, boot_bits_lock, app_write_block, app_read_block;
    logic boot_write_block, boot_read_block, irq_mask;
    logic [7:0] ext_prog_data, self_prog_data, lock_byte;
    wire  [8:0] fl = {ext_prog_block, ext_verify_block, fuse_lock, boot_bits_lock, app_write_block,
                      app_read_block, boot_write_block, boot_read_block, irq_mask};
    always #5 clk_sys = ~clk_sys;
    prog_model pm (.*);
    lock_bit_protection DUT (.*);
    // flag image expected from a byte and the executing section
    function automatic logic [8:0] flags(input logic [7:0] b, input logic e, input logic v);
        flags = {b[1:0] != 2'h3, b[1:0] == 2'h0, b[1:0] != 2'h3, b[1:0] == 2'h0, !b[2], !b[3] && e, !b[4], !b[5] && !e,
                 (!b[3] && v && !e) || (!b[5] && !v && e)};
    endfunction
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input logic [2:0] k, input logic [7:0] d, input logic e, input logic v, input logic [7:0] b);
        pm.req(k, d, e, v);
        @(posedge clk_sys);
        #1;
        check({1'b0, lock_byte}, {1'b0, b});
        check(fl, flags(b, e, v));
    endtask
    task automatic give_verdict();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #20000;
        errors++;
        give_verdict();
    end
    // request sequence with expected byte
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        step(3'h0, 8'hff, 1'b0, 1'b0, 8'hec);
        step(3'h4, 8'h00, 1'b0, 1'b0, 8'hff);
        step(3'h1, 8'hf8, 1'b0, 1'b0, 8'hfb);
        step(3'h1, 8'hf7, 1'b1, 1'b1, 8'hf3);
        step(3'h0, 8'hff, 1'b0, 1'b1, 8'hf3);
        step(3'h2, 8'hef, 1'b0, 1'b0, 8'he3);
        step(3'h2, 8'hdf, 1'b0, 1'b0, 8'hc3);
        step(3'h0, 8'hff, 1'b1, 1'b0, 8'hc3);
        step(3'h2, 8'hfe, 1'b0, 1'b0, 8'hc2);
        step(3'h2, 8'hfd, 1'b0, 1'b0, 8'hc0);
        step(3'h6, 8'h00, 1'b0, 1'b0, 8'hff);
        step(3'h1, 8'hd7, 1'b0, 1'b0, 8'hd7);
        step(3'h2, 8'hfe, 1'b1, 1'b0, 8'hd6);
        step(3'h2, 8'hfb, 1'b1, 1'b0, 8'hd6);
        step(3'h4, 8'h00, 1'b0, 1'b0, 8'hff);
        step(3'h2, 8'hfd, 1'b0, 1'b0, 8'hfd);
        give_verdict();
    end
endmodule
